// file: core/etc_pkg.sv
// constants, record layout and carrier types of the edge time-stamp capture block
// assumes a single 40 MHz clock and a head module that supplies a free-running microsecond ticker
// Summary of operation
// - variants: 20-byte image with 5 entries, or 60-byte image with 15 entries
// - input image length fixed per variant to 14h or 3Ch, never changed
// - output image length fixed at zero bytes, no output data consumed
// - per-channel delay code, default 02h; codes select 2 to 2731 microseconds
// - rising-edge byte bits 0-3 enable low-to-high capture; upper bits reserved, reset 00h
// - falling-edge byte bits 0-3 enable high-to-low capture; upper bits reserved, reset 00h
// - enabled filtered edge captures ticker and state of all inputs as one entry
// - new entry lands at offset zero, older entries move four bytes up
// - with the queue full, a new entry discards the oldest one
// - image lengths in record 02h, delays in 01h, edge selects in 80h
// - diagnostic record readable as 01h, its first four bytes as 00h
// - module information byte reads 1Fh: class 1111b plus channel information flag
// - channel kind byte reads 70h with bit 7 zero
// - diagnostic record reports four channels and zero diagnostic bits per channel
// - no interrupts; diagnostics only as readable record data
// - diagnostic ticker field holds ticker sampled when byte 0 of record 00h or 01h is read
package etc_pkg;

	// clock and microsecond time base
	localparam int        CLK_HZ      = 40000000;
	localparam int        US_PER_SEC  = 1000000;
	localparam int        TICK_CYCLES = CLK_HZ / US_PER_SEC;
	localparam int        NUM_CH      = 4;

	// variants
	localparam int        ENTRIES_SHORT = 5;
	localparam int        ENTRIES_LONG  = 15;
	localparam logic [7:0] IMG_LEN_SHORT = 8'h14;
	localparam logic [7:0] IMG_LEN_LONG  = 8'h3C;
	localparam logic [7:0] OUT_IMG_LEN   = 8'h00;

	// record numbers
	localparam logic [7:0] REC_DIAG_HEAD = 8'h00;
	localparam logic [7:0] REC_DELAY     = 8'h01;
	localparam logic [7:0] REC_LENGTHS   = 8'h02;
	localparam logic [7:0] REC_EDGES     = 8'h80;

	// record byte positions
	localparam logic [4:0] IDX_IN_LEN    = 5'h00;
	localparam logic [4:0] IDX_OUT_LEN   = 5'h01;
	localparam logic [4:0] IDX_RISE      = 5'h00;
	localparam logic [4:0] IDX_FALL      = 5'h01;
	localparam logic [4:0] IDX_MODINFO   = 5'h01;
	localparam logic [4:0] IDX_CHKIND    = 5'h04;
	localparam logic [4:0] IDX_DIAGBITS  = 5'h05;
	localparam logic [4:0] IDX_CHCOUNT   = 5'h06;
	localparam logic [4:0] IDX_SNAP      = 5'h10;
	localparam logic [4:0] DIAG_LEN      = 5'h14;
	localparam logic [4:0] DIAG_HEAD_LEN = 5'h04;

	// fixed diagnostic values
	localparam logic [7:0] MODULE_CLASS_INFO = 8'h1F;
	localparam logic [7:0] CHANNEL_KIND      = 8'h70;
	localparam logic [7:0] DIAG_BITS_PER_CH  = 8'h00;
	localparam logic [7:0] CHANNEL_COUNT     = 8'h04;

	// parameter reset values and field layout
	localparam logic [7:0] DELAY_RESET   = 8'h02;
	localparam logic [7:0] EDGE_RESET    = 8'h00;
	localparam logic [7:0] EDGE_MASK     = 8'h0F;

	// entry layout: byte +0 state, +1 running number, +2 ticker high, +3 ticker low
	localparam int        ENTRY_BYTES   = 4;

	// filter delay codes and their times in microseconds
	localparam logic [7:0] DLY_C0 = 8'h00;
	localparam logic [7:0] DLY_C1 = 8'h02;
	localparam logic [7:0] DLY_C2 = 8'h04;
	localparam logic [7:0] DLY_C3 = 8'h07;
	localparam logic [7:0] DLY_C4 = 8'h09;
	localparam logic [7:0] DLY_C5 = 8'h0C;
	localparam logic [11:0] DLY_US0 = 12'd2;
	localparam logic [11:0] DLY_US1 = 12'd4;
	localparam logic [11:0] DLY_US2 = 12'd12;
	localparam logic [11:0] DLY_US3 = 12'd86;
	localparam logic [11:0] DLY_US4 = 12'd342;
	localparam logic [11:0] DLY_US5 = 12'd2731;

	// record request from the head module
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] num;
		logic [4:0] idx;
		logic [7:0] wdata;
	} etc_rec_req_type;

	// record answer, one cycle after the request
	typedef struct packed {
		logic       ack;
		logic       err;
		logic [7:0] rdata;
	} etc_rec_rsp_type;

	// delay code to microseconds; zero marks a code that is not allowed
	function automatic logic [11:0] etc_delay_us(input logic [7:0] code);
		case (code)
			DLY_C0:  etc_delay_us = DLY_US0;
			DLY_C1:  etc_delay_us = DLY_US1;
			DLY_C2:  etc_delay_us = DLY_US2;
			DLY_C3:  etc_delay_us = DLY_US3;
			DLY_C4:  etc_delay_us = DLY_US4;
			DLY_C5:  etc_delay_us = DLY_US5;
			default: etc_delay_us = 12'h000;
		endcase
	endfunction : etc_delay_us

endpackage : etc_pkg

// file: core/etc_capture.sv
// edge time-stamp capture: input filters, edge selection, newest-first entry queue, record access
// assumes inputs and requests synchronous to clk; the head module drives the microsecond ticker
`timescale 1ns/1ps
`default_nettype none
module etc_capture #(
	parameter bit DEEP = 1'b0
) (
	// clock, reset, enable
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     ce,
	// field inputs and time base
	input  wire logic [3:0]               input_channel,
	input  wire logic [31:0]              us_ticker,
	input  wire logic                     sys_stopped,
	// record access
	input  wire etc_pkg::etc_rec_req_type rec_req,
	output var  etc_pkg::etc_rec_rsp_type rec_rsp,
	// input image read port
	input  wire logic                     img_rd,
	input  wire logic [5:0]               img_addr,
	output var  logic [7:0]               img_rdata
);

	localparam int         NENT    = DEEP ? etc_pkg::ENTRIES_LONG : etc_pkg::ENTRIES_SHORT;
	localparam logic [7:0] IMG_LEN = DEEP ? etc_pkg::IMG_LEN_LONG : etc_pkg::IMG_LEN_SHORT;

	typedef struct packed {
		logic [5:0]        pre;
		logic [3:0]        filt;
		logic [3:0][11:0]  cnt;
		logic [3:0][7:0]   dly;
		logic [3:0]        rise;
		logic [3:0]        fall;
		logic [7:0]        num;
		logic [14:0][31:0] q;
		logic [31:0]       snap;
		etc_pkg::etc_rec_rsp_type rsp;
		logic [7:0]        img;
	} etc_state_type;

	etc_state_type s_r;
	etc_state_type s_nxt;
	logic          tick;
	logic          hit;
	logic [7:0]    diag_b;
	logic [3:0]    ent;
	logic [31:0]   word;

	// fixed diagnostic byte or ticker snapshot byte for the current record index; reserved bytes stay zero
	always_comb begin
		diag_b = 8'h00;
		case (rec_req.idx)
			etc_pkg::IDX_MODINFO:  diag_b = etc_pkg::MODULE_CLASS_INFO;
			etc_pkg::IDX_CHKIND:   diag_b = etc_pkg::CHANNEL_KIND;
			etc_pkg::IDX_DIAGBITS: diag_b = etc_pkg::DIAG_BITS_PER_CH;
			etc_pkg::IDX_CHCOUNT:  diag_b = etc_pkg::CHANNEL_COUNT;
			default: begin
				if (rec_req.idx >= etc_pkg::IDX_SNAP) begin
					diag_b = s_r.snap[8 * (rec_req.idx[1:0]) +: 8];
				end
			end
		endcase
	end

	// entry word addressed by the image port
	always_comb begin
		ent  = img_addr[5:2];
		word = 32'h0000_0000;
		if (ent < 4'(NENT)) begin
			word = s_r.q[ent];
		end
	end

	// next state: time base, filters, queue, records, image read
	always_comb begin
		s_nxt = s_r;
		tick  = 1'b0;
		hit   = 1'b0;
		s_nxt.rsp.ack = 1'b0;
		// microsecond strobe from the local clock; its free-running phase can end a filter delay up to a microsecond early
		if (s_r.pre == 6'(etc_pkg::TICK_CYCLES - 1)) begin
			s_nxt.pre = 6'h00;
			tick      = 1'b1;
		end else begin
			s_nxt.pre = s_r.pre + 6'h01;
		end
		// an input must differ from the filtered level for the whole delay to pass
		for (int i = 0; i < etc_pkg::NUM_CH; i++) begin
			if (input_channel[i] == s_r.filt[i]) begin
				s_nxt.cnt[i] = 12'h000;
			end else if (tick) begin
				if (s_r.cnt[i] + 12'h001 >= etc_pkg::etc_delay_us(s_r.dly[i])) begin
					s_nxt.filt[i] = input_channel[i];
					s_nxt.cnt[i]  = 12'h000;
				end else begin
					s_nxt.cnt[i] = s_r.cnt[i] + 12'h001;
				end
			end
			if (s_r.rise[i] && s_nxt.filt[i] && !s_r.filt[i]) begin
				hit = 1'b1;
			end
			if (s_r.fall[i] && !s_nxt.filt[i] && s_r.filt[i]) begin
				hit = 1'b1;
			end
		end
		// edges on several channels in one cycle make a single entry
		if (hit) begin
			s_nxt.num = s_r.num + 8'h01;
			s_nxt.q   = {s_r.q[13:0], {4'h0, s_nxt.filt}, s_nxt.num, us_ticker[15:0]};
			for (int k = 0; k < 15; k++) begin
				if (k >= NENT) begin
					s_nxt.q[k] = 32'h0000_0000;
				end
			end
		end
		// record access; the answer follows one cycle later
		if (rec_req.rd || rec_req.wr) begin
			s_nxt.rsp.ack   = 1'b1;
			s_nxt.rsp.err   = 1'b0;
			s_nxt.rsp.rdata = 8'h00;
		end
		if (rec_req.rd) begin
			case (rec_req.num)
				etc_pkg::REC_DIAG_HEAD, etc_pkg::REC_DELAY: begin
					if (rec_req.idx == 5'h00) begin
						s_nxt.snap = us_ticker;
					end
					if (rec_req.idx < ((rec_req.num == etc_pkg::REC_DELAY) ? etc_pkg::DIAG_LEN
							: etc_pkg::DIAG_HEAD_LEN)) begin
						s_nxt.rsp.rdata = diag_b;
					end else begin
						s_nxt.rsp.err = 1'b1;
					end
				end
				etc_pkg::REC_LENGTHS: begin
					case (rec_req.idx)
						etc_pkg::IDX_IN_LEN:  s_nxt.rsp.rdata = IMG_LEN;
						etc_pkg::IDX_OUT_LEN: s_nxt.rsp.rdata = etc_pkg::OUT_IMG_LEN;
						default:              s_nxt.rsp.err   = 1'b1;
					endcase
				end
				etc_pkg::REC_EDGES: begin
					case (rec_req.idx)
						etc_pkg::IDX_RISE: s_nxt.rsp.rdata = {4'h0, s_r.rise};
						etc_pkg::IDX_FALL: s_nxt.rsp.rdata = {4'h0, s_r.fall};
						default:           s_nxt.rsp.err   = 1'b1;
					endcase
				end
				default: s_nxt.rsp.err = 1'b1;
			endcase
		end else if (rec_req.wr) begin
			case (rec_req.num)
				etc_pkg::REC_DELAY: begin
					// codes outside the table are refused and the old delay kept
					if (rec_req.idx < 5'(etc_pkg::NUM_CH)
							&& etc_pkg::etc_delay_us(rec_req.wdata) != 12'h000) begin
						s_nxt.dly[rec_req.idx[1:0]] = rec_req.wdata;
					end else begin
						s_nxt.rsp.err = 1'b1;
					end
				end
				etc_pkg::REC_LENGTHS: begin
					// lengths are fixed; only a rewrite of the same value while stopped is accepted
					case (rec_req.idx)
						etc_pkg::IDX_IN_LEN:
							s_nxt.rsp.err = !sys_stopped || rec_req.wdata != IMG_LEN;
						etc_pkg::IDX_OUT_LEN:
							s_nxt.rsp.err = !sys_stopped || rec_req.wdata != etc_pkg::OUT_IMG_LEN;
						default: s_nxt.rsp.err = 1'b1;
					endcase
				end
				etc_pkg::REC_EDGES: begin
					case (rec_req.idx)
						etc_pkg::IDX_RISE: s_nxt.rise = rec_req.wdata[3:0];
						etc_pkg::IDX_FALL: s_nxt.fall = rec_req.wdata[3:0];
						default:           s_nxt.rsp.err = 1'b1;
					endcase
				end
				default: s_nxt.rsp.err = 1'b1;
			endcase
		end
		// image bytes beyond the variant length read zero
		if (img_rd) begin
			s_nxt.img = 8'h00;
			if ({2'b00, img_addr} < IMG_LEN) begin
				s_nxt.img = word[8 * (3 - 32'(img_addr[1:0])) +: 8];
			end
		end
	end

	// state register; ce low freezes everything, entries clear at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r      <= '0;
			s_r.dly  <= {4{etc_pkg::DELAY_RESET}};
			s_r.rise <= etc_pkg::EDGE_RESET[3:0];
			s_r.fall <= etc_pkg::EDGE_RESET[3:0];
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flip-flops; there is no interrupt output at all
	assign rec_rsp   = s_r.rsp;
	assign img_rdata = s_r.img;

endmodule : etc_capture
`default_nettype wire

// file: dv/etc_capture_assertions.sv
// checker for the record and image ports of etc_capture
// assumes one clock domain; only requests taken with ce high are judged
`timescale 1ns/1ps
`default_nettype none
module etc_capture_assertions #(
	parameter bit DEEP = 1'b0
) (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rst_n,
	input wire logic                     ce,
	// field and time base
	input wire logic [3:0]               input_channel,
	input wire logic [31:0]              us_ticker,
	input wire logic                     sys_stopped,
	// record and image ports
	input wire etc_pkg::etc_rec_req_type rec_req,
	input wire etc_pkg::etc_rec_rsp_type rec_rsp,
	input wire logic                     img_rd,
	input wire logic [5:0]               img_addr,
	input wire logic [7:0]               img_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic       rd;
	logic       wr;
	logic [7:0] len;
	// read wins over write, so a write counts only without a read
	assign rd = ce && rec_req.rd;
	assign wr = ce && rec_req.wr && !rec_req.rd;
	assign len = DEEP ? 8'h3C : 8'h14;
	AST_ACK: assert property (rd || wr |=> rec_rsp.ack)
		else $error("ack missing");
	AST_MODINFO: assert property (rd && rec_req.num <= 8'h01 && rec_req.idx == 5'h01
		|=> rec_rsp.rdata == 8'h1F) else $error("module info");
	AST_KIND: assert property (rd && rec_req.num == 8'h01 && rec_req.idx == 5'h04
		|=> rec_rsp.rdata == 8'h70) else $error("channel kind");
	AST_COUNTS: assert property (rd && rec_req.num == 8'h01 && rec_req.idx inside {5'h05, 5'h06}
		|=> rec_rsp.rdata == {5'h00, $past(rec_req.idx) == 5'h06, 2'b00}) else $error("counts");
	AST_SPARE: assert property (rd && rec_req.num == 8'h01 && rec_req.idx inside {5'h02, 5'h03, [5'h07:5'h0F]}
		|=> rec_rsp.rdata == 8'h00 && !rec_rsp.err) else $error("spare byte");
	AST_LENGTHS: assert property (rd && rec_req.num == 8'h02 && rec_req.idx <= 5'h01
		|=> rec_rsp.rdata == ($past(rec_req.idx) == 5'h00 ? len : 8'h00)) else $error("length");
	AST_DELAY_BAD: assert property (wr && rec_req.num == 8'h01 && rec_req.idx <= 5'h03
		&& !(rec_req.wdata inside {8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0C}) |=> rec_rsp.err)
		else $error("bad delay taken");
	AST_LEN_WR: assert property (wr && rec_req.num == 8'h02 && !sys_stopped |=> rec_rsp.err)
		else $error("length write taken");
	AST_IMG_RANGE: assert property (ce && img_rd && {2'b00, img_addr} >= len |=> img_rdata == 8'h00)
		else $error("image beyond length");
endmodule : etc_capture_assertions
bind etc_capture etc_capture_assertions #(.DEEP(DEEP)) u_etc_capture_assertions (
	.clk(clk), .rst_n(rst_n), .ce(ce), .input_channel(input_channel), .us_ticker(us_ticker),
	.sys_stopped(sys_stopped), .rec_req(rec_req), .rec_rsp(rec_rsp), .img_rd(img_rd),
	.img_addr(img_addr), .img_rdata(img_rdata));
`default_nettype wire

// file: dv/etc_head_model.sv
// head module model: free-running microsecond ticker
// assumes the 40 MHz bench clock
`timescale 1ns/1ps
`default_nettype none
module etc_head_model (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// time base
	output var logic [31:0] us_ticker
);
	logic [5:0] div_r;
	// one microsecond each 40 cycles, so stamps track real time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 6'h00;
			us_ticker <= 32'h0;
		end else if (div_r == 6'h27) begin
			div_r <= 6'h00;
			us_ticker <= us_ticker + 32'h1;
		end else begin
			div_r <= div_r + 6'h01;
		end
	end
endmodule : etc_head_model
`default_nettype wire

// file: dv/etc_capture_tb_top.sv
// bench for etc_capture: record access, image reads, edge capture
// assumes the head model as ticker; a 5-entry and a 15-entry instance see the same stimulus
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module etc_capture_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, stopped = 1'b0, img_rd = 1'b0, err;
	logic [3:0] chan = 4'h0;
	logic [5:0] img_addr = 6'h00;
	logic [7:0] img_rdata, rdat;
	logic [15:0] ts;
	logic [31:0] us_ticker, t0, snap;
	logic [7:0] codes [6] = '{8'h0C, 8'h09, 8'h07, 8'h04, 8'h02, 8'h00};
	etc_pkg::etc_rec_req_type rec_req = '0;
	etc_pkg::etc_rec_rsp_type rec_rsp;
	etc_pkg::etc_rec_rsp_type rec_rsp_d;
	logic [7:0] img_rdata_d;
	int compares = 0;
	int miscompares = 0;
	always #12.5 clk = ~clk;
	etc_head_model u_etc_head_model (.clk(clk), .rst_n(rst_n), .us_ticker(us_ticker));
	etc_capture #(.DEEP(1'b0)) u_etc_capture (.clk(clk), .rst_n(rst_n), .ce(ce), .input_channel(chan),
		.us_ticker(us_ticker), .sys_stopped(stopped), .rec_req(rec_req), .rec_rsp(rec_rsp),
		.img_rd(img_rd), .img_addr(img_addr), .img_rdata(img_rdata));
	// the 15-entry variant runs beside the short one and is read through the same calls
	etc_capture #(.DEEP(1'b1)) u_etc_capture_deep (.clk(clk), .rst_n(rst_n), .ce(ce), .input_channel(chan),
		.us_ticker(us_ticker), .sys_stopped(stopped), .rec_req(rec_req), .rec_rsp(rec_rsp_d),
		.img_rd(img_rd), .img_addr(img_addr), .img_rdata(img_rdata_d));
	// one record access; the answer stands in the cycle after the taking edge
	task automatic rec(input logic r, input logic [7:0] n, input logic [4:0] i, input logic [7:0] d);
		@(negedge clk);
		rec_req = '{r, !r, n, i, d};
		@(negedge clk);
		rec_req = '0;
		`CHK("ack", 1'b1, rec_rsp.ack)
		rdat = rec_rsp.rdata;
		err = rec_rsp.err;
	endtask : rec
	// data of a refused read is left unchecked
	task automatic rchk(input logic [7:0] n, input logic [4:0] i, input logic [7:0] e, input logic ee);
		rec(1'b1, n, i, 8'h00);
		if (!ee) `CHK("record data", e, rdat)
		`CHK("record error", ee, err)
	endtask : rchk
	task automatic wchk(input logic [7:0] n, input logic [4:0] i, input logic [7:0] d, input logic ee);
		rec(1'b0, n, i, d);
		`CHK("write error", ee, err)
	endtask : wchk
	task automatic img(input logic [5:0] a);
		@(negedge clk);
		img_rd = 1'b1;
		img_addr = a;
		@(negedge clk);
		img_rd = 1'b0;
		rdat = img_rdata;
	endtask : img
	// 160 cycles cover the 2 us filter plus a microsecond of strobe phase
	task automatic drive(input logic [3:0] v);
		t0 = us_ticker;
		@(negedge clk);
		chan = v;
		repeat (160) @(negedge clk);
	endtask : drive
	task automatic entry(input logic [5:0] a, input logic [7:0] s, input logic [7:0] k);
		img(a);
		`CHK("entry state", s, rdat)
		img(a + 6'h01);
		`CHK("entry number", k, rdat)
	endtask : entry
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		img(6'h00);
		`CHK("empty image", 8'h00, rdat)
		rchk(8'h02, 5'h00, 8'h14, 1'b0);
		rchk(8'h02, 5'h01, 8'h00, 1'b0);
		rchk(8'h80, 5'h00, 8'h00, 1'b0);
		rchk(8'h80, 5'h01, 8'h00, 1'b0);
		rchk(8'h00, 5'h01, 8'h1F, 1'b0);
		rchk(8'h00, 5'h04, 8'h00, 1'b1);
		rchk(8'h01, 5'h04, 8'h70, 1'b0);
		rchk(8'h01, 5'h05, 8'h00, 1'b0);
		rchk(8'h01, 5'h06, 8'h04, 1'b0);
		rchk(8'h01, 5'h0B, 8'h00, 1'b0);
		rchk(8'h05, 5'h00, 8'h00, 1'b1);
		wchk(8'h02, 5'h00, 8'h14, 1'b1);
		stopped = 1'b1;
		wchk(8'h02, 5'h00, 8'h14, 1'b0);
		wchk(8'h02, 5'h00, 8'h3C, 1'b1);
		wchk(8'h01, 5'h00, 8'h01, 1'b1);
		// every legal code on every channel, ending on the 2 us code
		for (int c = 0; c < 4; c++) begin
			foreach (codes[j]) wchk(8'h01, c[4:0], codes[j], 1'b0);
		end
		wchk(8'h80, 5'h00, 8'hF1, 1'b0);
		wchk(8'h80, 5'h01, 8'hF2, 1'b0);
		rchk(8'h80, 5'h00, 8'h01, 1'b0);
		rchk(8'h80, 5'h01, 8'h02, 1'b0);
		drive(4'h2);
		img(6'h01);
		`CHK("rise not enabled", 8'h00, rdat)
		for (int k = 1; k <= 6; k++) begin
			drive(4'h3);
			img(6'h02);
			ts[15:8] = rdat;
			img(6'h03);
			ts[7:0] = rdat;
			`CHK("entry time", 1'b1, ts >= t0[15:0] && ts <= us_ticker[15:0])
			entry(6'h00, 8'h03, k[7:0]);
			entry(6'h04, k > 1 ? 8'h03 : 8'h00, k[7:0] - 8'h01);
			drive(4'h2);
		end
		drive(4'h0);
		entry(6'h00, 8'h00, 8'h07);
		entry(6'h10, 8'h03, 8'h03);
		img(6'h14);
		`CHK("past length", 8'h00, rdat)
		t0 = us_ticker;
		rchk(8'h00, 5'h00, 8'h00, 1'b0);
		for (int i = 0; i < 4; i++) begin
			rec(1'b1, 8'h01, 5'h10 + i[4:0], 8'h00);
			snap[8*i+:8] = rdat;
		end
		`CHK("snapshot", 1'b1, snap >= t0 && snap <= us_ticker)
		// ce low freezes the filters, so an edge during it makes no entry until ce returns
		ce = 1'b0;
		drive(4'h1);
		ce = 1'b1;
		img(6'h00);
		`CHK("frozen entry state", 8'h00, rdat)
		drive(4'h1);
		entry(6'h00, 8'h01, 8'h08);
		// eight entries: the short image lost entry 1, the long one still holds it at 1Ch
		img(6'h1C);
		`CHK("short image past length", 8'h00, rdat)
		`CHK("long image oldest state", 8'h03, img_rdata_d)
		img(6'h1D);
		`CHK("long image oldest number", 8'h01, img_rdata_d)
		rchk(8'h02, 5'h00, 8'h14, 1'b0);
		`CHK("long input length", 8'h3C, rec_rsp_d.rdata)
		summarize();
	end
	// hang guard, well beyond the few thousand cycles of the tests
	initial begin
		repeat (10000) @(posedge clk);
		miscompares++;
		summarize();
	end
endmodule : etc_capture_tb_top
`default_nettype wire
